// >>> hw/bld_core.sv
// bit and literal instruction decode and execute core
`default_nettype none
`include "bld_defines.svh"
module bld_core (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // instruction stream
  input  wire logic        instr_valid_in,
  input  wire logic [13:0] instr_in,
  input  wire logic        wake_in,
  // file register read side and port pins
  input  wire logic [7:0]  file_rdata_in,
  input  wire logic [7:0]  pins_in,
  // file register write side
  output logic             file_we_out,
  output logic [6:0]       file_waddr_out,
  output logic [7:0]       file_wdata_out,
  output logic             presc_clr_out,
  // program flow
  output logic             pc_load_out,
  output logic [10:0]      pc_target_out,
  output logic             stack_push_out,
  output logic             stack_pop_out,
  output logic             idle_cycle_out,
  output logic             standby_out,
  // core state
  output logic [7:0]       acc_out,
  output logic [4:0]       flags_out,
  // register port
  input  wire logic [1:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out
);
  import bld_pkg::*;

  function automatic bld_op_t decode(input logic [13:0] i);
    casez (i)
      `BLD_PAT_BCLR:    decode = OP_BCLR;
      `BLD_PAT_BSET:    decode = OP_BSET;
      `BLD_PAT_SKIPLO:  decode = OP_SKIPLO;
      `BLD_PAT_SKIPHI:  decode = OP_SKIPHI;
      `BLD_PAT_ADDK:    decode = OP_ADDK;
      `BLD_PAT_ANDK:    decode = OP_ANDK;
      `BLD_PAT_ORK:     decode = OP_ORK;
      `BLD_PAT_XORK:    decode = OP_XORK;
      `BLD_PAT_SUBK:    decode = OP_SUBK;
      `BLD_PAT_RETK:    decode = OP_RETK;
      `BLD_PAT_MOVK:    decode = OP_MOVK;
      `BLD_PAT_CALL:    decode = OP_CALL;
      `BLD_PAT_GOTO:    decode = OP_GOTO;
      `BLD_PAT_ADD_ACC_FILE:   decode = OP_ADD_ACC_FILE;
      `BLD_CODE_SLEEP:  decode = OP_SLEEP;
      `BLD_CODE_CLRWDT: decode = OP_CLRWDT;
      `BLD_CODE_RET:    decode = OP_RET;
      default:          decode = OP_IDLE;
    endcase
  endfunction : decode

  // state
  logic [7:0]  acc_r, acc_nxt;
  logic        carry_r, carry_nxt;
  logic        nib_r, nib_nxt;
  logic        zero_r, zero_nxt;
  logic        timeout_r, to_nxt;
  logic        pdown_r, pd_nxt;
  logic        standby_r, sleep_nxt;
  logic        flush_r, flush_nxt;
  logic        ctrl_presc_r;
  logic [7:0]  pins_s1_r, pins_s2_r;
  logic        we_r, we_nxt;
  logic [6:0]  waddr_r;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        presc_r;
  logic        jump_r, jump_nxt;
  logic [10:0] target_r;
  logic        push_r, push_nxt;
  logic        pop_r, pop_nxt;
  logic [7:0]  rdata_r;

  // decode
  wire bld_op_t    op       = decode(instr_in);
  wire logic       exec     = instr_valid_in && !flush_r && !standby_r;
  wire logic [7:0] imm      = instr_in[7:0];
  wire logic [6:0] f_addr   = instr_in[6:0];
  wire logic [2:0] bit_idx  = instr_in[9:7];
  wire logic       dest_f   = instr_in[7];
  // port reads see the pins so a driven-low input is written back low
  wire logic [7:0] file_op  = (f_addr == `BLD_IO_PORT_ADDR) ? pins_s2_r : file_rdata_in;
  wire logic [7:0] bit_mask = 8'(8'h01 << bit_idx);
  wire logic       bit_val  = file_op[bit_idx];
  wire logic [7:0] logic_res = (op == OP_ANDK) ? (acc_r & imm) :
                               (op == OP_ORK)  ? (acc_r | imm) : (acc_r ^ imm);
  wire logic       acc_wr   = reg_wr_in && (reg_addr_in == `BLD_REG_ACC);
  wire logic       ctrl_wr  = reg_wr_in && (reg_addr_in == `BLD_REG_CTRL);
  wire logic [7:0] reg_rsel = (reg_addr_in == `BLD_REG_ACC)   ? acc_r :
                              (reg_addr_in == `BLD_REG_FLAGS) ? {3'h0, flags_out} :
                              (reg_addr_in == `BLD_REG_CTRL)  ? {7'h00, ctrl_presc_r} : 8'h00;

  // subtraction is literal plus inverted accumulator plus one, so carry means no borrow
  wire logic       is_sub   = (op == OP_SUBK);
  wire logic [7:0] add_a    = is_sub ? imm : acc_r;
  wire logic [7:0] add_b    = is_sub ? ~acc_r : ((op == OP_ADD_ACC_FILE) ? file_op : imm);
  logic [7:0]      add_sum;
  logic            add_c;
  logic            add_dc;

  bld_nib_add #(
    .W (8)
  ) u_add (
    .a_in         (add_a),
    .b_in         (add_b),
    .cin_in       (is_sub),
    .sum_out      (add_sum),
    .cout_out     (add_c),
    .nib_cout_out (add_dc)
  );

  always_comb begin
    acc_nxt   = acc_wr ? reg_wdata_in : acc_r;
    carry_nxt = carry_r;
    nib_nxt   = nib_r;
    zero_nxt  = zero_r;
    to_nxt    = timeout_r;
    pd_nxt    = pdown_r;
    sleep_nxt = standby_r && !wake_in;
    flush_nxt = 1'b0;
    we_nxt    = 1'b0;
    wdata_nxt = file_op;
    jump_nxt  = 1'b0;
    push_nxt  = 1'b0;
    pop_nxt   = 1'b0;
    if (exec) begin
      unique case (op)
        OP_BCLR: begin
          we_nxt    = 1'b1;
          wdata_nxt = file_op & ~bit_mask;
        end
        OP_BSET: begin
          we_nxt    = 1'b1;
          wdata_nxt = file_op | bit_mask;
        end
        OP_SKIPLO: flush_nxt = !bit_val;
        OP_SKIPHI: flush_nxt = bit_val;
        OP_ADDK, OP_SUBK: begin
          acc_nxt   = add_sum;
          carry_nxt = add_c;
          nib_nxt   = add_dc;
          zero_nxt  = (add_sum == 8'h00);
        end
        OP_ADD_ACC_FILE: begin
          acc_nxt   = dest_f ? acc_nxt : add_sum;
          we_nxt    = dest_f;
          wdata_nxt = add_sum;
          carry_nxt = add_c;
          nib_nxt   = add_dc;
          zero_nxt  = (add_sum == 8'h00);
        end
        OP_ANDK, OP_ORK, OP_XORK: begin
          acc_nxt  = logic_res;
          zero_nxt = (logic_res == 8'h00);
        end
        OP_MOVK: acc_nxt = imm;
        OP_RETK: begin
          acc_nxt   = imm;
          pop_nxt   = 1'b1;
          flush_nxt = 1'b1;
        end
        OP_RET: begin
          pop_nxt   = 1'b1;
          flush_nxt = 1'b1;
        end
        OP_CALL, OP_GOTO: begin
          jump_nxt  = 1'b1;
          push_nxt  = (op == OP_CALL);
          flush_nxt = 1'b1;
        end
        OP_SLEEP: begin
          sleep_nxt = 1'b1;
          to_nxt    = 1'b1;
          pd_nxt    = 1'b0;
        end
        OP_CLRWDT: begin
          to_nxt = 1'b1;
          pd_nxt = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // pins come from outside the clock domain
  always_ff @(posedge clk_in) begin
    pins_s1_r <= pins_in;
    pins_s2_r <= pins_s1_r;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      acc_r     <= 8'h00;
      carry_r   <= 1'b0;
      nib_r     <= 1'b0;
      zero_r    <= 1'b0;
      timeout_r <= 1'b1;
      pdown_r   <= 1'b1;
      standby_r <= 1'b0;
      flush_r   <= 1'b0;
    end else begin
      acc_r     <= acc_nxt;
      carry_r   <= carry_nxt;
      nib_r     <= nib_nxt;
      zero_r    <= zero_nxt;
      timeout_r <= to_nxt;
      pdown_r   <= pd_nxt;
      standby_r <= sleep_nxt;
      flush_r   <= flush_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      we_r     <= 1'b0;
      waddr_r  <= 7'h00;
      wdata_r  <= 8'h00;
      presc_r  <= 1'b0;
      jump_r   <= 1'b0;
      target_r <= 11'h000;
      push_r   <= 1'b0;
      pop_r    <= 1'b0;
    end else begin
      we_r     <= we_nxt;
      waddr_r  <= f_addr;
      wdata_r  <= wdata_nxt;
      presc_r  <= we_nxt && (f_addr == `BLD_TIMER_ZERO_COUNT_ADDR) && ctrl_presc_r;
      jump_r   <= jump_nxt;
      target_r <= instr_in[10:0];
      push_r   <= push_nxt;
      pop_r    <= pop_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl_presc_r <= 1'(`BLD_CTRL_RESET);
      rdata_r      <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        ctrl_presc_r <= reg_wdata_in[`BLD_CTRL_PRESC_BIT];
      end
      rdata_r <= reg_rd_in ? reg_rsel : 8'h00;
    end
  end

  assign file_we_out    = we_r;
  assign file_waddr_out = waddr_r;
  assign file_wdata_out = wdata_r;
  assign presc_clr_out  = presc_r;
  assign pc_load_out    = jump_r;
  assign pc_target_out  = target_r;
  assign stack_push_out = push_r;
  assign stack_pop_out  = pop_r;
  assign idle_cycle_out = flush_r;
  assign standby_out    = standby_r;
  assign acc_out        = acc_r;
  assign flags_out      = {pdown_r, timeout_r, zero_r, nib_r, carry_r};
  assign reg_rdata_out  = rdata_r;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_run(bld_op_t o);
    exec && (op == o);
  endsequence
  sequence s_one_idle;
    idle_cycle_out ##1 !idle_cycle_out;
  endsequence

  property p_bclr;
    s_run(OP_BCLR) |=> file_we_out && !file_wdata_out[$past(bit_idx)] && $stable(flags_out);
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear wrong");
  property p_bset;
    s_run(OP_BSET) |=> file_we_out && file_wdata_out[$past(bit_idx)] && file_waddr_out == $past(f_addr);
  endproperty
  a_bset: assert property (p_bset) else $error("bit set wrong");
  property p_skiplo;
    s_run(OP_SKIPLO) ##0 !bit_val |=> s_one_idle;
  endproperty
  a_skiplo: assert property (p_skiplo) else $error("skip on low missing");
  property p_skiphi;
    s_run(OP_SKIPHI) ##0 bit_val |=> s_one_idle;
  endproperty
  a_skiphi: assert property (p_skiphi) else $error("skip on high missing");
  property p_addk;
    s_run(OP_ADDK) |=> acc_out == 8'($past(acc_r) + $past(imm)) && flags_out[`BLD_FLAG_Z] == (acc_out == 8'h00);
  endproperty
  a_addk: assert property (p_addk) else $error("add literal wrong");
  property p_andk;
    s_run(OP_ANDK) |=> acc_out == ($past(acc_r) & $past(imm)) && $stable(flags_out[`BLD_FLAG_C]);
  endproperty
  a_andk: assert property (p_andk) else $error("and literal wrong");
  property p_ork;
    s_run(OP_ORK) |=> acc_out == ($past(acc_r) | $past(imm)) && $stable(flags_out[`BLD_FLAG_DC]);
  endproperty
  a_ork: assert property (p_ork) else $error("or literal wrong");
  property p_xork;
    s_run(OP_XORK) |=> acc_out == ($past(acc_r) ^ $past(imm)) && flags_out[`BLD_FLAG_Z] == (acc_out == 8'h00);
  endproperty
  a_xork: assert property (p_xork) else $error("xor literal wrong");
  property p_subk;
    s_run(OP_SUBK) |=> acc_out == 8'($past(imm) - $past(acc_r)) && flags_out[`BLD_FLAG_C] == ($past(imm) >= $past(acc_r));
  endproperty
  a_subk: assert property (p_subk) else $error("subtract from literal wrong");
  property p_retk;
    s_run(OP_RETK) |=> stack_pop_out && acc_out == $past(imm) && $stable(flags_out) ##0 s_one_idle;
  endproperty
  a_retk: assert property (p_retk) else $error("return with literal wrong");
  property p_sleep;
    s_run(OP_SLEEP) |=> standby_out && flags_out[`BLD_FLAG_TO] && !flags_out[`BLD_FLAG_PD];
  endproperty
  a_sleep: assert property (p_sleep) else $error("standby entry wrong");
  property p_iosrc;
    s_run(OP_BSET) ##0 f_addr == `BLD_IO_PORT_ADDR |=> file_wdata_out == ($past(pins_s2_r) | $past(bit_mask));
  endproperty
  a_iosrc: assert property (p_iosrc) else $error("port operand not from pins");
  property p_presc;
    file_we_out && file_waddr_out == `BLD_TIMER_ZERO_COUNT_ADDR && $past(ctrl_presc_r) |-> presc_clr_out;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler not cleared");
  property p_twocyc;
    pc_load_out || stack_pop_out |-> s_one_idle;
  endproperty
  a_twocyc: assert property (p_twocyc) else $error("flow change not two cycles");
  property p_add_acc_file;
    s_run(OP_ADD_ACC_FILE) ##0 dest_f |=> file_we_out && file_wdata_out == 8'($past(acc_r) + $past(file_op));
  endproperty
  a_add_acc_file: assert property (p_add_acc_file) else $error("add to file wrong");
  property p_call;
    s_run(OP_CALL) |=> pc_load_out && stack_push_out && pc_target_out == $past(instr_in[10:0]);
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
endmodule : bld_core
`default_nettype wire

// >>> inc/bld_defines.svh
// constants for the bit and literal instruction decode core
`ifndef BLD_DEFINES_SVH
`define BLD_DEFINES_SVH

// instruction patterns, x bits written as ?
`define BLD_PAT_BCLR   14'b01_00??_????_????
`define BLD_PAT_BSET   14'b01_01??_????_????
`define BLD_PAT_SKIPLO 14'b01_10??_????_????
`define BLD_PAT_SKIPHI 14'b01_11??_????_????
`define BLD_PAT_ADDK   14'b11_111?_????_????
`define BLD_PAT_ANDK   14'b11_1001_????_????
`define BLD_PAT_ORK    14'b11_1000_????_????
`define BLD_PAT_XORK   14'b11_1010_????_????
`define BLD_PAT_SUBK   14'b11_110?_????_????
`define BLD_PAT_RETK   14'b11_01??_????_????
`define BLD_PAT_MOVK   14'b11_00??_????_????
`define BLD_PAT_CALL   14'b10_0???_????_????
`define BLD_PAT_GOTO   14'b10_1???_????_????
`define BLD_PAT_ADD_ACC_FILE  14'b00_0111_????_????
`define BLD_CODE_SLEEP  14'h0063
`define BLD_CODE_CLRWDT 14'h0064
`define BLD_CODE_RET    14'h0008

// file register map seen by this core
`define BLD_IO_PORT_ADDR 7'h05
`define BLD_TIMER_ZERO_COUNT_ADDR    7'h01

// flag positions in flags_out
`define BLD_FLAG_C  0
`define BLD_FLAG_DC 1
`define BLD_FLAG_Z  2
`define BLD_FLAG_TO 3
`define BLD_FLAG_PD 4

// register port map
`define BLD_REG_ACC   2'h0
`define BLD_REG_FLAGS 2'h1
`define BLD_REG_CTRL  2'h2
`define BLD_CTRL_PRESC_BIT 0
`define BLD_CTRL_RESET     8'h00

`endif

// >>> inc/bld_pkg.sv
// types for the bit and literal instruction decode core
`default_nettype none
package bld_pkg;
  typedef enum logic [4:0] {
    OP_IDLE   = 5'b00000,
    OP_BCLR   = 5'b00001,
    OP_BSET   = 5'b00010,
    OP_SKIPLO = 5'b00011,
    OP_SKIPHI = 5'b00100,
    OP_ADDK   = 5'b00101,
    OP_ANDK   = 5'b00110,
    OP_ORK    = 5'b00111,
    OP_XORK   = 5'b01000,
    OP_SUBK   = 5'b01001,
    OP_RETK   = 5'b01010,
    OP_MOVK   = 5'b01011,
    OP_CALL   = 5'b01100,
    OP_GOTO   = 5'b01101,
    OP_RET    = 5'b01110,
    OP_SLEEP  = 5'b01111,
    OP_CLRWDT = 5'b10000,
    OP_ADD_ACC_FILE  = 5'b10001
  } bld_op_t;
endpackage : bld_pkg
`default_nettype wire

// >>> hw/bld_nib_add.sv
// adder with carry out of the low nibble and of the whole word
`default_nettype none
module bld_nib_add #(
  parameter int unsigned W = 8
) (
  // operands
  input  wire logic [W-1:0] a_in,
  input  wire logic [W-1:0] b_in,
  input  wire logic         cin_in,
  // results
  output logic [W-1:0]      sum_out,
  output logic              cout_out,
  output logic              nib_cout_out
);
  logic [4:0] low_w;
  logic [W:0] full_w;

  assign low_w        = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin_in};
  assign full_w       = {1'b0, a_in} + {1'b0, b_in} + {{W{1'b0}}, cin_in};
  assign sum_out      = full_w[W-1:0];
  assign cout_out     = full_w[W];
  assign nib_cout_out = low_w[4];
endmodule : bld_nib_add
`default_nettype wire

// >>> tb/tb_bld_core.sv
// self-checking testbench for the bit and literal instruction decode core
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module tb_bld_core;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in, nrst_in, instr_valid_in, wake_in, reg_wr_in, reg_rd_in;
  logic [13:0] instr_in;
  logic [7:0]  file_rdata_in, pins_in, reg_wdata_in, reg_rdata_out, acc_out, file_wdata_out;
  logic [1:0]  reg_addr_in;
  logic        file_we_out, presc_clr_out, pc_load_out, stack_push_out, stack_pop_out;
  logic        idle_cycle_out, standby_out;
  logic [6:0]  file_waddr_out;
  logic [10:0] pc_target_out;
  logic [4:0]  flags_out;
  // snapshot of the one-cycle outputs after the first instruction
  logic        s_we, s_presc, s_load, s_push, s_pop, s_idle;
  logic [6:0]  s_waddr;
  logic [7:0]  s_wdata, rv;
  logic [10:0] s_tgt;
  logic [4:0]  ef;
  logic [12:0] r;
  logic [2:0]  bb;
  int          n_mismatch, tests_run;
  localparam logic [13:0] IDLE_CYCLE = 14'h0000;
  // literal table: opcode bits 13:8, accumulator, literal; x bits both ways
  logic [5:0]  l_op [8] = '{6'h3E, 6'h3F, 6'h3C, 6'h3D, 6'h39, 6'h38, 6'h3A, 6'h3E};
  logic [7:0]  l_a  [8] = '{8'hFF, 8'h08, 8'h01, 8'h20, 8'hF0, 8'h00, 8'h5A, 8'h12};
  logic [7:0]  l_k  [8] = '{8'h01, 8'h08, 8'h10, 8'h10, 8'h0F, 8'h00, 8'h5A, 8'h34};
  // skip table: test kind, bit, file data, taken
  logic [1:0]  k_op [4] = '{2'b10, 2'b10, 2'b11, 2'b11};
  logic [2:0]  k_b  [4] = '{3'h0, 3'h7, 3'h7, 3'h7};
  logic [7:0]  k_rd [4] = '{8'hFE, 8'h80, 8'h80, 8'h7F};
  logic        k_tk [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  // flow table: word, {load, push, pop}; target is the word's low 11 bits
  logic [13:0] f_w  [3] = '{14'h27FF, 14'h2AA5, 14'h0008};
  logic [2:0]  f_p  [3] = '{3'b110, 3'b100, 3'b001};

  bld_core i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .wake_in(wake_in), .file_rdata_in(file_rdata_in), .pins_in(pins_in), .file_we_out(file_we_out),
    .file_waddr_out(file_waddr_out), .file_wdata_out(file_wdata_out), .presc_clr_out(presc_clr_out),
    .pc_load_out(pc_load_out), .pc_target_out(pc_target_out), .stack_push_out(stack_push_out),
    .stack_pop_out(stack_pop_out), .idle_cycle_out(idle_cycle_out), .standby_out(standby_out),
    .acc_out(acc_out), .flags_out(flags_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // expected accumulator and flags of a literal operation
  function automatic logic [12:0] lit_exp(input logic [5:0] op, input logic [7:0] a, input logic [7:0] k,
                                          input logic [4:0] fi);
    logic [8:0] s;
    logic [4:0] f;
    logic [7:0] q;
    f = fi;
    q = 8'h00;
    s = {1'b0, a} + {1'b0, k};
    case (op)
      6'h3E, 6'h3F: begin
        q = s[7:0];
        f[0] = s[8];
        f[1] = ({1'b0, a[3:0]} + {1'b0, k[3:0]}) > 5'h0F;
      end
      6'h3C, 6'h3D: begin
        q = k - a;
        f[0] = (k >= a);
        f[1] = (k[3:0] >= a[3:0]);
      end
      6'h39: q = a & k;
      6'h38: q = a | k;
      6'h3A: q = a ^ k;
      default: q = a;
    endcase
    f[2] = (q == 8'h00);
    return {f, q};
  endfunction : lit_exp

  // two words back to back; the second lands in the cycle a skip or jump discards
  task automatic issue2(input logic [13:0] w1, input logic [7:0] rd, input logic [13:0] w2);
    @(posedge clk_in);
    instr_in <= w1;
    instr_valid_in <= 1'b1;
    file_rdata_in <= rd;
    @(posedge clk_in);
    instr_in <= w2;
    #1;
    {s_we, s_presc, s_load, s_push, s_pop, s_idle} = {file_we_out, presc_clr_out, pc_load_out,
                                                      stack_push_out, stack_pop_out, idle_cycle_out};
    {s_waddr, s_wdata, s_tgt} = {file_waddr_out, file_wdata_out, pc_target_out};
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask : issue2

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : reg_read

  task automatic results;
    $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // watchdog: the sequence needs well under 20 us
  initial begin
    #100us;
    n_mismatch++;
    $display("watchdog expired");
    results();
  end

  initial begin
    {nrst_in, instr_valid_in, wake_in, reg_wr_in, reg_rd_in} = 5'b00000;
    {instr_in, file_rdata_in, reg_wdata_in, reg_addr_in} = '0;
    pins_in = 8'h3C;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1;
    ef = 5'h18;
    `CHK("flags_reset", ef, flags_out)
    reg_write(2'h1, 8'h00);
    reg_read(2'h1, rv);
    `CHK("flags_read", {3'b000, ef}, rv)
    reg_read(2'h3, rv);
    `CHK("unmapped_read", 8'h00, rv)
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      reg_write(2'h0, l_a[i]);
      r = lit_exp(l_op[i], l_a[i], l_k[i], ef);
      issue2({l_op[i], l_k[i]}, 8'h00, IDLE_CYCLE);
      ef = r[12:8];
      `CHK("lit_acc", r[7:0], acc_out)
      `CHK("lit_flags", ef, flags_out)
      `CHK("lit_idle", 1'b0, s_idle)
    end
    $display("test literal done");

    for (int i = 0; i < 8; i++) begin
      bb = i[2:0];
      issue2({4'b0100, bb, 7'h7F - 7'(i)}, 8'hA5, IDLE_CYCLE);
      `CHK("clr_we", 1'b1, s_we)
      `CHK("clr_addr", 7'h7F - 7'(i), s_waddr)
      `CHK("clr_data", 8'hA5 & ~(8'h01 << i), s_wdata)
      issue2({4'b0101, bb, 7'h00 + 7'(i)}, 8'hA5, IDLE_CYCLE);
      `CHK("set_addr", 7'h00 + 7'(i), s_waddr)
      // address 5 is the port, so the synchronised pins replace the file data there
      `CHK("set_data", ((i == 5) ? 8'h3C : 8'hA5) | (8'h01 << i), s_wdata)
      `CHK("bit_flags", ef, flags_out)
    end
    $display("test bit done");

    for (int i = 0; i < 4; i++) begin
      reg_write(2'h0, 8'h00);
      issue2({2'b01, k_op[i], k_b[i], 7'h40}, k_rd[i], {6'h30, 8'h50 + 8'(i)});
      `CHK("skip_idle", k_tk[i], s_idle)
      `CHK("skip_we", 1'b0, s_we)
      `CHK("skip_acc", k_tk[i] ? 8'h00 : 8'h50 + 8'(i), acc_out)
    end
    $display("test skip done");

    issue2(14'h37C3, 8'h00, 14'h3011);
    `CHK("retk_acc", 8'hC3, acc_out)
    `CHK("retk_flow", 2'b11, {s_pop, s_idle})
    `CHK("retk_flags", ef, flags_out)
    for (int i = 0; i < 3; i++) begin
      issue2(f_w[i], 8'h00, 14'h3022);
      `CHK("flow_pulses", f_p[i], {s_load, s_push, s_pop})
      `CHK("flow_idle", 1'b1, s_idle)
      `CHK("flow_acc", 8'hC3, acc_out)
      if (f_p[i][2]) `CHK("flow_target", f_w[i][10:0], s_tgt)
    end
    $display("test flow done");

    reg_write(2'h0, 8'h88);
    r = lit_exp(6'h3E, 8'h88, 8'h88, ef);
    issue2(14'h0730, 8'h88, IDLE_CYCLE);
    ef = r[12:8];
    `CHK("add_acc_file_acc", r[7:0], acc_out)
    `CHK("add_acc_file_flags", ef, flags_out)
    r = lit_exp(6'h3E, r[7:0], 8'hF0, ef);
    issue2(14'h07B0, 8'hF0, IDLE_CYCLE);
    ef = r[12:8];
    `CHK("add_acc_file_we", 1'b1, s_we)
    `CHK("add_acc_file_wdata", r[7:0], s_wdata)
    `CHK("add_acc_file_keep", 8'h10, acc_out)
    `CHK("add_acc_file_flags", ef, flags_out)
    $display("test add file done");

    issue2(14'h1405, 8'hFF, IDLE_CYCLE);
    `CHK("port_wdata", 8'h3D, s_wdata)
    reg_write(2'h2, 8'h01);
    issue2(14'h1381, 8'hFF, IDLE_CYCLE);
    `CHK("presc_clr", 2'b11, {s_we, s_presc})
    issue2(14'h0781, 8'h01, IDLE_CYCLE);
    `CHK("presc_add", 1'b1, s_presc)
    issue2(14'h0701, 8'h01, IDLE_CYCLE);
    `CHK("presc_d0", 1'b0, s_presc)
    // both adds of 0x01 to 0x10 leave carry, nibble carry and zero low
    ef[2:0] = 3'b000;
    `CHK("presc_add_flags", ef, flags_out)
    `CHK("presc_add_acc", 8'h11, acc_out)
    issue2(14'h1402, 8'h00, IDLE_CYCLE);
    `CHK("presc_other", 1'b0, s_presc)
    reg_write(2'h2, 8'h00);
    issue2(14'h1401, 8'h00, IDLE_CYCLE);
    `CHK("presc_unassigned", 2'b10, {s_we, s_presc})
    $display("test port and timer done");

    reg_write(2'h0, 8'hA7);
    reg_read(2'h0, rv);
    `CHK("acc_read", 8'hA7, rv)
    issue2(14'h0063, 8'h00, 14'h3099);
    ef[4] = 1'b0;
    `CHK("standby", 1'b1, standby_out)
    `CHK("standby_flags", ef, flags_out)
    issue2(14'h3042, 8'h00, IDLE_CYCLE);
    `CHK("standby_acc", 8'hA7, acc_out)
    @(posedge clk_in);
    wake_in <= 1'b1;
    @(posedge clk_in);
    wake_in <= 1'b0;
    #1;
    `CHK("wake", 1'b0, standby_out)
    issue2(14'h0064, 8'h00, IDLE_CYCLE);
    ef[4:3] = 2'b11;
    `CHK("clrwdt_flags", ef, flags_out)
    $display("test standby done");
    results();
  end
endmodule : tb_bld_core
`default_nettype wire
